// File: hdl/flash_program_erase_powerdown_seq.sv
// Purpose: link decoder and core sequencer for program, erase, sleep
// Assumes: link clock sclk stops outside frames; frame end crossed by toggle
// Notes:   page buffer lives in this module; array writes leave as strobes
`timescale 1ns/100ps
`default_nettype none
module flash_program_erase_powerdown_seq
    import flash_seq_pkg::*;
#(
    parameter int PROG_CYCLES  = PROG_CYC,
    parameter int ERASE_CYCLES = SECTOR_CYC,
    parameter int CHIP_CYCLES  = CE_CYC,
    parameter int ADDR_W       = 24
) (
    // core clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // serial link
    input  wire logic              sclk,
    input  wire logic              cs_n,
    input  wire logic [3:0]        lane_in,
    // protection settings
    input  wire logic [4:0]        protect_bits,
    input  wire logic              protect_complement,
    // status
    output logic                   busy_flag,
    output logic                   write_enable_latch,
    output logic                   deep_sleep,
    // array write strobes
    output logic                   prog_strobe,
    output logic [ADDR_W-1:0]      prog_addr,
    output logic [7:0]             prog_data,
    output logic                   erase_strobe,
    output logic [2:0]             erase_kind,
    output logic [ADDR_W-1:0]      erase_addr
);
    import flash_seq_pkg::*;
    initial begin
        if (ADDR_W != 24 || PROG_CYCLES <= PAGE_BYTES || ERASE_CYCLES < 1 || CHIP_CYCLES < 1)
            $error("unsupported parameters");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // how the block is put together
    //
    // two clock domains meet here:
    //   - the link side runs on sclk
    //   - the sequencer runs on core_clk
    // sclk only moves while cs_n is low,
    // so nothing on the link side may
    // rely on an idle clock to settle.
    //
    // the link side counts bits per frame
    // and captures opcode and address.
    // opcode and address use lane0 only;
    // program data uses all four lanes,
    // high nibble first.
    //
    // data bytes go into a page buffer
    // at a column that wraps in the page,
    // so a long burst keeps the last
    // page worth of bytes only.
    // a bit map marks columns that got
    // data; untouched columns are never
    // written to the array.
    //
    // on cs_n rising the link side flips
    // a toggle and freezes the bit count
    // and opcode of the frame just ended.
    // the core side sees the toggle
    // through three flops and treats a
    // difference of the last two as one
    // frame end event.
    //
    // the frozen count and opcode are
    // read only at that event; they stay
    // put until the next frame ends,
    // which the host spaces well apart.
    //
    // limitation: the address register
    // is shared by both sides, so a new
    // frame during a program cycle would
    // move the stream address. the host
    // is expected to wait for busy low.
    //
    // trade-off: the page buffer is read
    // across domains without a handshake.
    // that is safe only because the link
    // side leaves it alone once cs_n is
    // high and the core reads it later.
    //
    // the program stream visits every
    // column once, so the program time
    // must cover a full page of cycles;
    // the check above refuses a page or less.
    //
    // erase kinds only start a strobe;
    // the array side wipes the region.
    // the whole address goes out, and
    // the array side picks the unit.
    //
    // sleep is entered after a delay,
    // and left by wake or reset pair;
    // after wake the block counts the
    // release time before going idle.
    //
    // all outputs are flops reset by rst.

    ////////////////////////////////////////////////////////////////////////////////
    // link domain: shift opcode, address and data on sclk rising edge
    logic [7:0]  op_reg;            // captured opcode
    logic [23:0] adr_reg;           // captured address
    logic [11:0] bitc_reg;          // bit count in frame, four per quad clock
    logic [7:0]  shift_reg;         // data byte shifter
    logic [8:0]  nbytes_reg;        // data bytes received
    logic [7:0]  buf_mem [0:PAGE_BYTES-1]; // page buffer, link side writes
    logic [7:0]  wptr_reg;          // page-wrapping write column
    logic [PAGE_BYTES-1:0] hit_reg; // columns that received data
    logic        frame_tog_reg = 1'b0; // toggles on every frame end, starts known
    logic        quad;              // data phase uses all lanes
    assign quad = (op_reg == OP_QPP) && (bitc_reg >= 12'd32);

    // frame is cleared by chip select itself, since sclk idles between frames
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            bitc_reg <= 12'd0;
        end else if (bitc_reg < 12'hff8) begin
            bitc_reg <= quad ? bitc_reg + 12'd4 : bitc_reg + 12'd1;
        end
    end

    // opcode then address, one lane, MSB first
    always_ff @(posedge sclk) begin
        if (!cs_n && bitc_reg < 12'd8)
            op_reg <= {op_reg[6:0], lane_in[0]};
        if (!cs_n && bitc_reg >= 12'd8 && bitc_reg < 12'd32)
            adr_reg <= {adr_reg[22:0], lane_in[0]};
    end

    // quad data nibbles, wrapping inside the page
    always_ff @(posedge sclk) begin
        if (!cs_n && quad) begin
            shift_reg <= {shift_reg[3:0], lane_in};
            if (bitc_reg[2]) begin
                buf_mem[wptr_reg] <= {shift_reg[3:0], lane_in};
            end
        end
    end

    // byte counters and touched-column map
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            nbytes_reg <= 9'd0;
        end else if (quad && bitc_reg[2] && nbytes_reg != 9'h1ff) begin
            nbytes_reg <= nbytes_reg + 9'd1;
        end
    end
    always_ff @(posedge sclk) begin
        if (!cs_n && bitc_reg == 12'd31) begin
            wptr_reg <= {adr_reg[6:0], lane_in[0]};
            hit_reg  <= '0;
        end else if (!cs_n && quad && bitc_reg[2]) begin
            wptr_reg <= wptr_reg + 8'd1;
            hit_reg[wptr_reg] <= 1'b1;
        end
    end

    // frame end event, counter values are stable while cs_n is high
    logic [11:0] end_bits_reg;
    logic [7:0]  end_op_reg;
    always_ff @(posedge cs_n) begin
        frame_tog_reg <= ~frame_tog_reg;
        end_bits_reg  <= bitc_reg;
        end_op_reg    <= op_reg;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // core domain: three stage toggle synchroniser
    logic [2:0] tog_sync_reg;
    logic       frame_end;
    always_ff @(posedge core_clk) begin
        if (rst) tog_sync_reg <= 3'b000;
        else     tog_sync_reg <= {tog_sync_reg[1:0], frame_tog_reg};
    end
    assign frame_end = tog_sync_reg[2] ^ tog_sync_reg[1];

    // classify the finished frame
    logic      exact8;
    logic      exact32;
    logic      whole_data;
    op_kind_t  kind;
    assign exact8     = (end_bits_reg == 12'd8);
    assign exact32    = (end_bits_reg == 12'd32);
    assign whole_data = (end_bits_reg > 12'd32) && (end_bits_reg[2:0] == 3'd0);
    always_comb begin
        kind = K_NONE;
        case (end_op_reg)
            OP_QPP:         if (whole_data) kind = K_PROG;
            OP_SECTOR:      if (exact32)    kind = K_SECTOR;
            OP_BE32:        if (exact32)    kind = K_BE32;
            OP_BE64:        if (exact32)    kind = K_BE64;
            OP_CE_A, OP_CE_B: if (exact8)  kind = K_CE;
            OP_SLEEP:       if (exact8)     kind = K_SLEEP;
            OP_WAKE:        kind = K_WAKE;
            default:        kind = K_NONE;
        endcase
    end

    // protection: bit4 picks 4KB grain, bits 2..0 size, bit3 from the bottom else from the top, complement inverts
    function automatic logic is_protected(input logic [23:0] a, input logic [4:0] bp,
                                          input logic cmp);
        logic [3:0] n;
        logic [23:0] lo;
        logic in_range;
        n  = {1'b0, bp[2:0]};
        lo = 24'h0;
        in_range = 1'b0;
        if (bp[2:0] != 3'd0) begin
            // top start is the region size taken from zero, modulo the array
            if (bp[4]) lo = 24'h00_0000 - (24'h1000 << (n - 4'd1));
            else       lo = 24'h00_0000 - (24'h4_0000 << (n - 4'd1));
            in_range = bp[3] ? (a < (24'h00_0000 - lo)) : (a >= lo);
        end
        is_protected = cmp ? ~in_range : in_range;
    endfunction : is_protected

    logic prot_hit;
    logic chip_ok;
    assign prot_hit = is_protected(adr_reg, protect_bits, protect_complement);
    assign chip_ok  = (protect_bits[2:0] == 3'b000 && !protect_complement) ||
                      (protect_bits[2:0] == 3'b111 &&  protect_complement);

    ////////////////////////////////////////////////////////////////////////////////
    // core sequencer
    //
    // idle waits for a frame end event.
    // a sleep request is taken without
    // the latch; program and erase need
    // the latch, the right bit count and
    // an open region.
    //
    // program and erase run a counter;
    // busy follows the state one cycle
    // late, since it is a registered copy.
    // the latch is dropped on the first
    // busy cycle, well before the end.
    //
    // frames during busy are dropped:
    // the busy states never look at the
    // frame end event, so a sleep or a
    // new command cannot cut a cycle.
    //
    // sleep entry counts the entry delay
    // first; a frame in that window is
    // not decoded either.
    //
    // in sleep only wake, or the reset
    // enable followed at once by reset,
    // move on; anything in between
    // disarms the pair.
    //
    // wake counts the release time, and
    // frames then are dropped as well.
    //
    // hazard: the event is one cycle
    // wide; every state that uses it
    // must test it in that same cycle.
    //
    typedef enum logic [2:0] {
        S_IDLE = 3'b000, S_PROG = 3'b001, S_ERASE = 3'b011, S_DPENT = 3'b010,
        S_SLEEP = 3'b110, S_WAKE = 3'b111
    } seq_state_t;
    seq_state_t  state_reg;
    logic [31:0] cnt_reg;
    logic [8:0]  col_reg;
    logic        wel_set;
    logic        rst_armed_reg;

    // write enable arrives as its own short frame
    assign wel_set = frame_end && end_op_reg == OP_WR_ENABLE && exact8 && state_reg == S_IDLE;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= S_IDLE;
            cnt_reg   <= '0;
            col_reg   <= 9'(PAGE_BYTES);
            rst_armed_reg <= 1'b0;
        end else begin
            // step the array stream one column per cycle while programming
            if (state_reg == S_PROG && col_reg < 9'(PAGE_BYTES))
                col_reg <= col_reg + 9'd1;
            case (state_reg)
                // sleep needs no latch, so it is tested first
                S_IDLE: if (frame_end && kind == K_SLEEP) begin
                    state_reg <= S_DPENT;
                    cnt_reg   <= 32'(SLEEP_CYC);
                end else if (frame_end && write_enable_latch) begin
                    case (kind)
                        K_PROG: if (!prot_hit) begin
                            state_reg <= S_PROG;
                            cnt_reg   <= 32'(PROG_CYCLES);
                            col_reg   <= '0;
                        end
                        K_SECTOR, K_BE32, K_BE64: if (!prot_hit) begin
                            state_reg <= S_ERASE;
                            cnt_reg   <= 32'(ERASE_CYCLES);
                        end
                        K_CE: if (chip_ok) begin
                            state_reg <= S_ERASE;
                            cnt_reg   <= 32'(CHIP_CYCLES);
                        end
                        default: ;
                    endcase
                end
                S_PROG, S_ERASE: if (cnt_reg <= 32'd1) state_reg <= S_IDLE;
                                 else cnt_reg <= cnt_reg - 32'd1;
                S_DPENT: if (cnt_reg <= 32'd1) state_reg <= S_SLEEP;
                         else cnt_reg <= cnt_reg - 32'd1;
                S_SLEEP: if (frame_end) begin
                    if (end_op_reg == OP_RST_EN && exact8) rst_armed_reg <= 1'b1;
                    else rst_armed_reg <= 1'b0;
                    if (kind == K_WAKE || (rst_armed_reg && end_op_reg == OP_RST && exact8)) begin
                        state_reg <= S_WAKE;
                        cnt_reg   <= 32'(RES_CYC);
                    end
                end
                S_WAKE: if (cnt_reg <= 32'd1) state_reg <= S_IDLE;
                        else cnt_reg <= cnt_reg - 32'd1;
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // array write stream from buffer after program start, only touched columns
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prog_strobe <= 1'b0;
            prog_addr   <= '0;
            prog_data   <= '0;
        end else begin
            prog_strobe <= 1'b0;
            if (state_reg == S_PROG && col_reg < 9'(PAGE_BYTES)) begin
                prog_strobe <= hit_reg[col_reg[7:0]];
                prog_addr   <= {adr_reg[23:8], col_reg[7:0]};
                prog_data   <= buf_mem[col_reg[7:0]];
            end
        end
    end

    // erase strobe once per accepted erase
    always_ff @(posedge core_clk) begin
        if (rst) begin
            erase_strobe <= 1'b0;
            erase_kind   <= 3'd0;
            erase_addr   <= '0;
        end else begin
            erase_strobe <= 1'b0;
            if (state_reg == S_IDLE && frame_end && write_enable_latch &&
                (((kind == K_SECTOR || kind == K_BE32 || kind == K_BE64) && !prot_hit) ||
                 (kind == K_CE && chip_ok))) begin
                erase_strobe <= 1'b1;
                erase_kind   <= kind;
                erase_addr   <= adr_reg;
            end
        end
    end

    // status outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy_flag          <= 1'b0;
            write_enable_latch <= 1'b0;
            deep_sleep         <= 1'b0;
        end else begin
            busy_flag  <= (state_reg == S_PROG || state_reg == S_ERASE);
            deep_sleep <= (state_reg == S_SLEEP);
            if (wel_set)
                write_enable_latch <= 1'b1;
            else if (state_reg == S_PROG || state_reg == S_ERASE)
                write_enable_latch <= 1'b0;
        end
    end
endmodule : flash_program_erase_powerdown_seq
`default_nettype wire

// File: hdl/flash_seq_pkg.sv
// Purpose: constants for the flash program/erase/power-down sequencer
// Assumes: serial link mode 0, commands MSB first
// Notes:   times are in ns and converted to core_clk cycles
package flash_seq_pkg;
    localparam logic [7:0] OP_WR_ENABLE = 8'h06;
    localparam logic [7:0] OP_QPP       = 8'h32;
    localparam logic [7:0] OP_SECTOR    = 8'h20;
    localparam logic [7:0] OP_BE32      = 8'h52;
    localparam logic [7:0] OP_BE64      = 8'hD8;
    localparam logic [7:0] OP_CE_A      = 8'h60;
    localparam logic [7:0] OP_CE_B      = 8'hC7;
    localparam logic [7:0] OP_SLEEP     = 8'hB9;
    localparam logic [7:0] OP_WAKE      = 8'hAB;
    localparam logic [7:0] OP_RST_EN    = 8'h66;
    localparam logic [7:0] OP_RST       = 8'h99;
    localparam int CLK_NS       = 20;
    localparam int PROG_NS      = 400_000;
    localparam int SECTOR_NS    = 1_000_000;
    localparam int CE_NS        = 4_000_000;
    localparam int SLEEP_NS     = 3_000;
    localparam int RES_NS       = 20_000;
    localparam int PROG_CYC     = PROG_NS / CLK_NS;
    localparam int SECTOR_CYC   = SECTOR_NS / CLK_NS;
    localparam int CE_CYC       = CE_NS / CLK_NS;
    localparam int SLEEP_CYC    = (SLEEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RES_CYC      = (RES_NS + CLK_NS - 1) / CLK_NS;
    localparam int PAGE_BYTES   = 256;
    // kind of operation carried across
    typedef enum logic [2:0] {
        K_NONE = 3'd0, K_PROG = 3'd1, K_SECTOR = 3'd2, K_BE32 = 3'd3,
        K_BE64 = 3'd4, K_CE = 3'd5, K_SLEEP = 3'd6, K_WAKE = 3'd7
    } op_kind_t;
endpackage : flash_seq_pkg

// File: tb/flash_seq_monitor.sv
// Purpose: port checks for the program/erase/sleep sequencer
// Assumes: cycle counts shortened to no less than 9
// Notes:   bound into every sequencer instance
`timescale 1ns/100ps
`default_nettype none
module flash_seq_monitor
    import flash_seq_pkg::*;
#(
    parameter int CHIP_CYCLES = CE_CYC
) (
    // clock, reset, select, protection
    input wire logic       core_clk, rst, cs_n, protect_complement,
    input wire logic [4:0] protect_bits,
    // status and strobes
    input wire logic       busy_flag, write_enable_latch, deep_sleep, prog_strobe, erase_strobe,
    input wire logic [2:0] erase_kind
);
    ////////////////////////////////////////////////////////////
    int unsigned busy_len; // cycles in the current busy span
    logic [1:0]  es_busy;  // erase strobes in one busy span, saturating
    // counters, since repetitions this long would choke the tools
    always_ff @(posedge core_clk) begin
        busy_len <= (rst || !busy_flag) ? 0 : busy_len + 1;
    end
    always_ff @(posedge core_clk) begin
        if (rst || !busy_flag)
            es_busy <= 2'd0;
        else if (erase_strobe && es_busy != 2'd3)
            es_busy <= es_busy + 2'd1;
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence busy_soon_s; ##[0:1] busy_flag; endsequence
    sequence cycle_end_s; busy_flag ##1 !busy_flag; endsequence
    erase_busy_a: assert property (erase_strobe |-> busy_soon_s)
        else $error("erase strobe without busy");
    erase_kind_a: assert property (erase_strobe |-> erase_kind inside {3'd2, 3'd3, 3'd4, 3'd5})
        else $error("bad erase kind");
    chip_open_a: assert property (erase_strobe && erase_kind == K_CE |->
        (protect_bits[2:0] == 3'h0 && !protect_complement) || (protect_bits[2:0] == 3'h7 && protect_complement))
        else $error("chip erase while protected");
    latch_clear_a: assert property (cycle_end_s |-> !write_enable_latch)
        else $error("latch set after cycle");
    busy_max_a: assert property (busy_len <= CHIP_CYCLES + 8)
        else $error("busy too long");
    busy_min_a: assert property ($rose(busy_flag) |=> busy_flag[*8])
        else $error("busy too short");
    one_cycle_a: assert property (es_busy <= 2'd1)
        else $error("second erase while busy");
    sleep_entry_a: assert property ($rose(deep_sleep) |-> !busy_flag && cs_n && $past(cs_n, 8))
        else $error("sleep entered wrongly");
    sleep_quiet_a: assert property (deep_sleep |-> !erase_strobe && !prog_strobe && !busy_flag)
        else $error("activity while asleep");
    frame_end_a: assert property (erase_strobe |-> cs_n && $past(cs_n, 2))
        else $error("erase before deselect");
endmodule : flash_seq_monitor
bind flash_program_erase_powerdown_seq flash_seq_monitor #(.CHIP_CYCLES(CHIP_CYCLES)) i_flash_seq_monitor (.*);
`default_nettype wire

// File: tb/flash_host_model.sv
// Purpose: host controller model driving select, link clock and lanes
// Assumes: link clock 80 ns, mode 0, parked low between frames
// Notes:   the bench builds frames through the frame task
`timescale 1ns/100ps
`default_nettype none
module flash_host_model (
    // link pins toward the device
    output var logic       sclk,
    output var logic       cs_n,
    output var logic [3:0] lane_in
);
    // idle: deselected, clock parked low
    initial begin
        sclk    = 1'b0;
        cs_n    = 1'b1;
        lane_in = 4'h0;
    end
    // lanes change in the low phase, device samples on the rise
    task automatic tick(input logic [3:0] v);
        lane_in = v;
        #40 sclk = 1'b1;
        #40 sclk = 1'b0;
    endtask : tick
    // opcode and address on lane0, nd quad bytes, then cut stray nibbles
    task automatic frame(input logic [7:0] op, input int na, input logic [23:0] a, input int nd, input int cut);
        logic [7:0] d;
        #(23 - $time % 20); // keep link edges clear of core edges
        cs_n = 1'b0;
        for (int i = 7; i >= 0; i--)
            tick({3'h0, op[i]});
        for (int i = 8 * na - 1; i >= 0; i--)
            tick({3'h0, a[i]});
        for (int i = 0; i < nd; i++) begin
            d = 8'(i + (i >> 8) * 64);
            tick(d[7:4]);
            tick(d[3:0]);
        end
        for (int i = 0; i < cut; i++)
            tick(4'h5);
        #40 cs_n = 1'b1;
        lane_in = ~lane_in; // released lanes no longer hold the last level
        #400;
    endtask : frame
endmodule : flash_host_model
`default_nettype wire

// File: tb/flash_program_erase_powerdown_seq_tb.sv
// Purpose: self-checking bench for the program/erase/sleep sequencer
// Assumes: shortened cycle counts; protect 0 leaves the array open
// Notes:   strobes are logged at the falling core edge
`timescale 1ns/100ps
`default_nettype none
module flash_program_erase_powerdown_seq_tb;
    import flash_seq_pkg::*;
    localparam int PROG_CYCLES = 300, ERASE_CYCLES = 40, CHIP_CYCLES = 600;
    logic        core_clk, rst, sclk, cs_n, protect_complement;
    logic [3:0]  lane_in;
    logic [4:0]  protect_bits;
    logic        busy_flag, write_enable_latch, deep_sleep, prog_strobe, erase_strobe;
    logic [23:0] prog_addr, erase_addr, last_eaddr;
    logic [7:0]  prog_data;
    logic [2:0]  erase_kind, last_kind;
    int          fail_count = 0, num_checks = 0, pcnt = 0, ecnt = 0;
    logic [7:0]  mem [int]; // last byte written per address
    flash_program_erase_powerdown_seq #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES),
        .CHIP_CYCLES(CHIP_CYCLES), .ADDR_W(24)) i_flash_program_erase_powerdown_seq (.*);
    flash_host_model i_flash_host_model (.*);
    ////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // strobe log, read where outputs are settled
    always @(negedge core_clk) begin
        if (prog_strobe === 1'b1) begin
            mem[int'(prog_addr)] = prog_data;
            pcnt++;
        end
        if (erase_strobe === 1'b1) begin
            ecnt++;
            last_kind = erase_kind;
            last_eaddr = erase_addr;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check
    // bounded wait for the cycle to end, then n+1 more cycles
    task automatic idle(input int n);
        for (int i = 0; i < 5000 && busy_flag !== 1'b0; i++)
            @(negedge core_clk);
        repeat (n + 1) @(negedge core_clk);
    endtask : idle
    task automatic cmd(input logic [7:0] op, input int na, input logic [23:0] a, input int nd, input int cut);
        i_flash_host_model.frame(op, na, a, nd, cut);
    endtask : cmd
    task automatic refused(input logic [7:0] op, input int na, input int nd, input int cut, input bit write_enable_cmd,
                           input logic [23:0] a = 24'h00_0100);
        pcnt = 0;
        ecnt = 0;
        if (write_enable_cmd)
            cmd(8'h06, 0, 0, 0, 0);
        cmd(op, na, a, nd, cut);
        idle(300);
        check(ecnt + pcnt + busy_flag, 0, "frame not ignored");
    endtask : refused
    task automatic t_refuse();
        refused(8'h20, 3, 0, 0, 0);
        refused(8'h32, 3, 2, 0, 0);
        refused(8'h20, 3, 0, 1, 1);
        refused(8'hD8, 2, 0, 0, 1);
        refused(8'h32, 3, 2, 1, 1);
        refused(8'h60, 0, 0, 1, 1);
        @(posedge core_clk);
        protect_bits <= 5'h07;
        refused(8'hC7, 0, 0, 0, 1);
        @(posedge core_clk);
        protect_complement <= 1'b1;
        cmd(8'h06, 0, 0, 0, 0);
        cmd(8'h60, 0, 0, 0, 0);
        idle(0);
        check(ecnt, 1, "chip erase complement");
        @(posedge core_clk);
        protect_bits <= 5'h00;
        protect_complement <= 1'b0;
        @(posedge core_clk);
        protect_bits <= 5'h01;
        refused(8'h20, 3, 0, 0, 1, 24'hFF_0000);
        refused(8'h32, 3, 1, 0, 1, 24'hFF_0100);
        @(posedge core_clk);
        protect_bits <= 5'h00;
    endtask : t_refuse
    task automatic t_erase();
        logic [7:0] op [5] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};
        int         sh [3] = '{12, 15, 16};
        for (int k = 0; k < 5; k++) begin
            ecnt = 0;
            cmd(8'h06, 0, 0, 0, 0);
            check(write_enable_latch, 1, "latch set");
            cmd(op[k], k < 3 ? 3 : 0, 24'h0A_BCDE, 0, 0);
            check(busy_flag, 1, "busy");
            idle(0);
            check(ecnt, 1, "erase count");
            check(last_kind, k < 3 ? k + 2 : 5, "erase kind");
            if (k < 3)
                check(last_eaddr >> sh[k], 24'h0A_BCDE >> sh[k], "erase unit");
            check(write_enable_latch, 0, "latch cleared");
        end
    endtask : t_erase
    task automatic t_program();
        pcnt = 0;
        cmd(8'h06, 0, 0, 0, 0);
        cmd(8'h32, 3, 24'h00_0410, 3, 0);
        idle(300);
        check(pcnt, 3, "short count");
        for (int i = 0; i < 3; i++)
            check(mem[24'h410 + i], i, "short data");
        check(mem.exists(24'h413) + mem.exists(24'h40F), 0, "rest of page");
        pcnt = 0;
        cmd(8'h06, 0, 0, 0, 0);
        cmd(8'h32, 3, 24'h00_0500, 257, 0);
        idle(300);
        check(pcnt, 256, "long count");
        check(mem[24'h500], 8'h40, "last byte wins");
        check(mem[24'h501], 8'h01, "page wrap");
    endtask : t_program
    task automatic t_busy();
        ecnt = 0;
        cmd(8'h06, 0, 0, 0, 0);
        cmd(8'hC7, 0, 0, 0, 0);
        cmd(8'h06, 0, 0, 0, 0);
        cmd(8'h20, 3, 24'h00_2000, 0, 0);
        cmd(8'hB9, 0, 0, 0, 0);
        check(busy_flag, 1, "still busy");
        idle(200);
        check(ecnt + write_enable_latch + deep_sleep, 1, "busy frames dropped");
    endtask : t_busy
    task automatic t_sleep();
        for (int w = 0; w < 2; w++) begin
            ecnt = 0;
            cmd(8'hB9, 0, 0, 0, 0);
            idle(50);
            check(deep_sleep, 0, "entry delay");
            idle(150);
            check(deep_sleep, 1, "asleep");
            cmd(8'h06, 0, 0, 0, 0);
            cmd(8'h20, 3, 24'h00_3000, 0, 0);
            idle(10);
            check(ecnt + write_enable_latch + deep_sleep, 1, "ignored asleep");
            if (w == 0)
                cmd(8'hAB, 0, 0, 0, 0);
            else begin
                cmd(8'h66, 0, 0, 0, 0);
                cmd(8'h99, 0, 0, 0, 0);
            end
            idle(1100);
            check(deep_sleep, 0, "awake");
        end
        cmd(8'hB9, 0, 0, 1, 0);
        idle(250);
        check(deep_sleep, 0, "cut sleep frame");
    endtask : t_sleep
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        rst                <= 1'b1;
        protect_bits       <= 5'h00;
        protect_complement <= 1'b0;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        idle(2);
        check(busy_flag + write_enable_latch + deep_sleep, 0, "reset state");
        t_refuse();
        t_erase();
        t_program();
        t_busy();
        t_sleep();
        end_of_test();
    end
    // cut a hang short
    initial begin
        #1_000_000;
        fail_count++;
        end_of_test();
    end
endmodule : flash_program_erase_powerdown_seq_tb
`default_nettype wire
